// ===== logic/irr_pkg.sv
// Constants for the interrupt and DMA request routing block
package irr_pkg;

    // ==========================================================
    // Interrupt controller of the general-purpose core
    // ==========================================================
    localparam int CPU_IRQ_N          = 40;
    localparam int CPU_IRQ_DSP_ACC    = 39;
    localparam int CPU_IRQ_XDOM_MST   = 38;
    localparam int CPU_IRQ_XDOM_SLV   = 34;

    // ==========================================================
    // Interrupt unit of the signal processor
    // ==========================================================
    localparam int DSP_IRQ_N          = 48;
    localparam int DSP_IRQ_SNOOP      = 6;
    localparam int DSP_IRQ_DMA_BRK    = 3;
    localparam int DSP_IRQ_DMA_ERR    = 2;

    // ==========================================================
    // DMA request routing
    // ==========================================================
    localparam int DSP_DMA_REQ_N      = 48;
    localparam int DSP_DMA_CH_N       = 16;
    localparam int DSP_DMA_PER_CH     = 3;
    localparam int DSP_DMA_SEL_W      = 2;
    localparam int CPU_DMA_REQ_N      = 16;
    localparam int CPU_DMA_SHARED     = 5;
    // Request lines that are active low at the peripheral
    localparam logic [15:0] CPU_DMA_LOW_MASK = 16'hf0c0;

    // Bus error interrupt index
    localparam int BERR_DSP_ACC       = 0;
    localparam int BERR_XDOM_MST      = 1;
    localparam int BERR_XDOM_SLV      = 2;
    localparam int BERR_N             = 3;

endpackage

// ===== logic/irr_req_cond.sv
// Per-line request conditioner: polarity and edge or level trigger
`timescale 1ns/1ns
`default_nettype none
module irr_req_cond (
    input  wire logic clk_in,       // System clock
    input  wire logic rst_b_in,     // Synchronous reset, active low
    input  wire logic raw_in,       // Raw request line
    input  wire logic pol_high_in,  // 1: active high, 0: active low
    input  wire logic edge_mode_in, // 1: edge triggered, 0: level
    input  wire logic clr_in,       // Clears a latched edge
    output logic      req_out       // Conditioned request, active high
);
    logic act;
    logic prev_q;
    logic prev_d;
    logic pend_q;
    logic pend_d;
    logic req_q;
    logic req_d;

    always_comb begin
        act    = pol_high_in ? raw_in : ~raw_in;
        prev_d = act;
        // Set wins over clear; level mode keeps no stale edge for a later switch
        pend_d = edge_mode_in & ((act & ~prev_q) | (pend_q & ~clr_in));
        req_d  = edge_mode_in ? pend_d : act;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            prev_q <= 1'b0;
            pend_q <= 1'b0;
            req_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            pend_q <= pend_d;
            req_q  <= req_d;
        end
    end

    assign req_out = req_q;
endmodule
`default_nettype wire

// ===== logic/irr_top.sv
// Routing of interrupt sources, bus error interrupts and DMA requests
//
// How it works
// - Any error response to a signal-processor master raises the access error interrupt.
// - Core master erroring on signal-processor space raises the cross-domain master error interrupt.
// - Signal-processor master erroring on core space raises the cross-domain slave error interrupt.
// - Signal-processor DMA takes 48 request inputs, each edge or level by choice.
// - Each signal-processor DMA channel owns three inputs; software picks the trigger.
// - Core-domain DMA uses 16 requests with fixed trigger type.
// - Core-domain DMA request 5 comes from card interface 1 or display request 4.
// - Signal-processor non-maskable interrupt follows the core's software interrupt, active high.
// - Signal-processor source 3 is DMA breakpoint, source 2 is DMA error.
// - Signal-processor source 6 is the internal bus snoop event.
// - Every core interrupt source is active-high level, not configurable.
// - Signal-processor sources have configurable polarity and edge or level trigger.
`timescale 1ns/1ns
`default_nettype none
module irr_top
    import irr_pkg::*;
#(
    parameter int CPU_IRQS  = CPU_IRQ_N,
    parameter int DSP_IRQS  = DSP_IRQ_N,
    parameter int DSP_REQS  = DSP_DMA_REQ_N,
    parameter int DSP_CHS   = DSP_DMA_CH_N,
    parameter int CPU_REQS  = CPU_DMA_REQ_N
) (
    input  wire logic                         clk_in,               // System bus clock
    input  wire logic                         rst_b_in,             // Synchronous reset, active low
    // Bus error events
    input  wire logic                         dsp_mst_err_in,       // Error response to a DSP-side master
    input  wire logic                         dsp_mst_tgt_cpu_in,   // That access targeted core space
    input  wire logic                         cpu_mst_dsp_err_in,   // Core master error on DSP space
    input  wire logic [BERR_N-1:0]            berr_clr_in,          // Clear bus error interrupts
    // Core interrupt controller side
    input  wire logic [CPU_IRQS-1:0]          cpu_irq_src_in,       // Peripheral sources, active high
    output logic      [CPU_IRQS-1:0]          cpu_irq_out,          // Sources to core controller
    // Signal processor interrupt unit side
    input  wire logic                         cpu_sw_nmi_in,        // Software interrupt set by core
    input  wire logic                         dma_brk_in,           // DSP DMA breakpoint event
    input  wire logic                         dma_err_in,           // DSP DMA error event
    input  wire logic                         bus_snoop_in,         // DSP internal bus snoop event
    input  wire logic [DSP_IRQS-1:0]          dsp_irq_src_in,       // Other DSP interrupt sources
    input  wire logic [DSP_IRQS-1:0]          dsp_irq_pol_in,       // 1: active high
    input  wire logic [DSP_IRQS-1:0]          dsp_irq_edge_in,      // 1: edge triggered
    input  wire logic [DSP_IRQS-1:0]          dsp_irq_clr_in,       // Clears a latched edge
    output logic      [DSP_IRQS-1:0]          dsp_irq_out,          // Conditioned DSP sources
    output logic                              dsp_nmi_out,          // DSP non-maskable interrupt
    // Signal processor DMA side
    input  wire logic [DSP_REQS-1:0]          dsp_dreq_in,          // Hardware requests, active high
    input  wire logic [DSP_REQS-1:0]          dsp_dreq_edge_in,     // 1: edge triggered
    input  wire logic [DSP_REQS-1:0]          dsp_dreq_clr_in,      // Clears a latched edge
    input  wire logic [DSP_CHS*DSP_DMA_SEL_W-1:0] dsp_ch_sel_in,   // Per channel trigger select
    output logic      [DSP_CHS-1:0]           dsp_ch_req_out,       // Request per channel
    // Core DMA side
    input  wire logic [CPU_REQS-1:0]          cpu_dreq_in,          // Requests at peripheral polarity
    input  wire logic                         card1_dreq_in,        // Card interface 1 request
    input  wire logic                         disp4_dreq_in,        // Display request 4
    input  wire logic                         shared_sel_disp_in,   // 1: display drives shared line
    output logic      [CPU_REQS-1:0]          cpu_dma_req_out       // Requests to core DMA, active high
);

    // ==========================================================
    // Bus error interrupts
    // ==========================================================
    logic [BERR_N-1:0] berr_q;
    logic [BERR_N-1:0] berr_d;
    logic [BERR_N-1:0] berr_set;

    always_comb begin
        berr_set                = '0;
        berr_set[BERR_DSP_ACC]  = dsp_mst_err_in;
        berr_set[BERR_XDOM_MST] = cpu_mst_dsp_err_in;
        berr_set[BERR_XDOM_SLV] = dsp_mst_err_in & dsp_mst_tgt_cpu_in;
        // Set wins over clear
        berr_d = berr_set | (berr_q & ~berr_clr_in);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            berr_q <= '0;
        end else begin
            berr_q <= berr_d;
        end
    end

    // ==========================================================
    // Core interrupt sources, fixed high level
    // ==========================================================
    logic [CPU_IRQS-1:0] cpu_irq_q;
    logic [CPU_IRQS-1:0] cpu_irq_d;

    always_comb begin
        cpu_irq_d                   = cpu_irq_src_in;
        cpu_irq_d[CPU_IRQ_DSP_ACC]  = berr_q[BERR_DSP_ACC];
        cpu_irq_d[CPU_IRQ_XDOM_MST] = berr_q[BERR_XDOM_MST];
        cpu_irq_d[CPU_IRQ_XDOM_SLV] = berr_q[BERR_XDOM_SLV];
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cpu_irq_q <= '0;
        end else begin
            cpu_irq_q <= cpu_irq_d;
        end
    end

    assign cpu_irq_out = cpu_irq_q;

    // ==========================================================
    // Signal processor interrupt sources
    // ==========================================================
    logic [DSP_IRQS-1:0] dsp_raw;
    logic                nmi_q;
    logic                nmi_d;

    always_comb begin
        dsp_raw                  = dsp_irq_src_in;
        dsp_raw[DSP_IRQ_DMA_BRK] = dma_brk_in;
        dsp_raw[DSP_IRQ_DMA_ERR] = dma_err_in;
        dsp_raw[DSP_IRQ_SNOOP]   = bus_snoop_in;
        nmi_d                    = cpu_sw_nmi_in;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= nmi_d;
        end
    end

    assign dsp_nmi_out = nmi_q;

    for (genvar i = 0; i < DSP_IRQS; i++) begin : g_dsp_irq
        irr_req_cond u_cond (
            .clk_in       (clk_in),
            .rst_b_in     (rst_b_in),
            .raw_in       (dsp_raw[i]),
            .pol_high_in  (dsp_irq_pol_in[i]),
            .edge_mode_in (dsp_irq_edge_in[i]),
            .clr_in       (dsp_irq_clr_in[i]),
            .req_out      (dsp_irq_out[i])
        );
    end

    // ==========================================================
    // Signal processor DMA requests
    // ==========================================================
    logic [DSP_REQS-1:0] dreq_cond;
    logic [DSP_CHS-1:0]  ch_req_q;
    logic [DSP_CHS-1:0]  ch_req_d;

    for (genvar r = 0; r < DSP_REQS; r++) begin : g_dsp_dreq
        irr_req_cond u_cond (
            .clk_in       (clk_in),
            .rst_b_in     (rst_b_in),
            .raw_in       (dsp_dreq_in[r]),
            .pol_high_in  (1'b1),
            .edge_mode_in (dsp_dreq_edge_in[r]),
            .clr_in       (dsp_dreq_clr_in[r]),
            .req_out      (dreq_cond[r])
        );
    end

    always_comb begin
        logic [DSP_DMA_SEL_W-1:0] sel;
        sel      = '0;
        ch_req_d = '0;
        for (int c = 0; c < DSP_CHS; c++) begin
            sel = dsp_ch_sel_in[c*DSP_DMA_SEL_W +: DSP_DMA_SEL_W];
            // Select code 3 picks no input
            if (sel < DSP_DMA_SEL_W'(DSP_DMA_PER_CH)) begin
                ch_req_d[c] = dreq_cond[c*DSP_DMA_PER_CH + int'(sel)];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ch_req_q <= '0;
        end else begin
            ch_req_q <= ch_req_d;
        end
    end

    assign dsp_ch_req_out = ch_req_q;

    // ==========================================================
    // Core DMA requests, fixed level trigger
    // ==========================================================
    logic [CPU_REQS-1:0] cpu_dreq_q;
    logic [CPU_REQS-1:0] cpu_dreq_d;
    logic [CPU_REQS-1:0] cpu_raw;

    always_comb begin
        cpu_raw                 = cpu_dreq_in;
        cpu_raw[CPU_DMA_SHARED] = shared_sel_disp_in ? disp4_dreq_in
                                                     : card1_dreq_in;
        // Active-low lines are turned to high level
        cpu_dreq_d = cpu_raw ^ CPU_DMA_LOW_MASK[CPU_REQS-1:0];
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cpu_dreq_q <= '0;
        end else begin
            cpu_dreq_q <= cpu_dreq_d;
        end
    end

    assign cpu_dma_req_out = cpu_dreq_q;

endmodule
`default_nettype wire

// ===== tb/irr_sva.sv
// Assertions on the ports of the request routing block
`timescale 1ns/1ns
`default_nettype none
module irr_chk
    import irr_pkg::*;
#(
    parameter int CPU_IRQS = CPU_IRQ_N,
    parameter int DSP_IRQS = DSP_IRQ_N,
    parameter int CPU_REQS = CPU_DMA_REQ_N
) (
    input wire logic                clk_in,             // Clock
    input wire logic                rst_b_in,           // Reset
    input wire logic                dsp_mst_err_in,     // DSP error
    input wire logic                dsp_mst_tgt_cpu_in, // Core target
    input wire logic                cpu_mst_dsp_err_in, // Core error
    input wire logic [BERR_N-1:0]   berr_clr_in,        // Clears
    input wire logic [CPU_IRQS-1:0] cpu_irq_src_in,     // Core sources
    input wire logic [CPU_IRQS-1:0] cpu_irq_out,        // Core irqs
    input wire logic                cpu_sw_nmi_in,      // Soft nmi
    input wire logic                dsp_nmi_out,        // DSP nmi
    input wire logic                dma_brk_in,         // Breakpoint
    input wire logic                bus_snoop_in,       // Snoop
    input wire logic [DSP_IRQS-1:0] dsp_irq_pol_in,     // Polarity
    input wire logic [DSP_IRQS-1:0] dsp_irq_edge_in,    // Trigger
    input wire logic [DSP_IRQS-1:0] dsp_irq_out,        // DSP irqs
    input wire logic                card1_dreq_in,      // Card
    input wire logic                disp4_dreq_in,      // Display
    input wire logic                shared_sel_disp_in, // Select
    input wire logic [CPU_REQS-1:0] cpu_dma_req_out     // Core DMA
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================
    // Level sources held for two samples
    sequence snoop_s;
        (bus_snoop_in && dsp_irq_pol_in[DSP_IRQ_SNOOP] && !dsp_irq_edge_in[DSP_IRQ_SNOOP])[*2];
    endsequence
    sequence brk_s;
        (dma_brk_in && dsp_irq_pol_in[DSP_IRQ_DMA_BRK] && !dsp_irq_edge_in[DSP_IRQ_DMA_BRK])[*2];
    endsequence
    acc_err_a: assert property (dsp_mst_err_in |-> ##2 cpu_irq_out[CPU_IRQ_DSP_ACC])
        else $error("access error interrupt missing");
    xdom_mst_a: assert property (cpu_mst_dsp_err_in |-> ##2 cpu_irq_out[CPU_IRQ_XDOM_MST])
        else $error("master error interrupt missing");
    xdom_slv_a: assert property (dsp_mst_err_in && dsp_mst_tgt_cpu_in |-> ##2 cpu_irq_out[CPU_IRQ_XDOM_SLV])
        else $error("slave error interrupt missing");
    berr_hold_a: assert property (cpu_irq_out[CPU_IRQ_DSP_ACC] && !$past(berr_clr_in[0]) |=> cpu_irq_out[CPU_IRQ_DSP_ACC])
        else $error("access error dropped without clear");
    nmi_follow_a: assert property ($past(rst_b_in) |-> dsp_nmi_out == $past(cpu_sw_nmi_in))
        else $error("nmi does not follow software interrupt");
    core_level_a: assert property ($past(rst_b_in) |-> cpu_irq_out[0] == $past(cpu_irq_src_in[0]))
        else $error("core source not level routed");
    shared_req_a: assert property ($past(rst_b_in) |-> cpu_dma_req_out[CPU_DMA_SHARED] ==
        ($past(shared_sel_disp_in) ? $past(disp4_dreq_in) : $past(card1_dreq_in)))
        else $error("shared request wrongly selected");
    snoop_src_a: assert property (snoop_s |=> dsp_irq_out[DSP_IRQ_SNOOP])
        else $error("snoop source missing");
    brk_src_a: assert property (brk_s |=> dsp_irq_out[DSP_IRQ_DMA_BRK])
        else $error("breakpoint source missing");
endmodule
`default_nettype wire

// ===== tb/irr_far.sv
// Far side model: DSP interrupt unit and DMA engine acknowledging requests
`timescale 1ns/1ns
`default_nettype none
module irr_far
    import irr_pkg::*;
(
    input  wire logic                     clk_in,       // Clock
    input  wire logic                     ack_en_in,    // Acknowledge enable
    input  wire logic [DSP_IRQ_N-1:0]     irq_in,       // DSP irqs
    input  wire logic [DSP_DMA_CH_N-1:0]  ch_req_in,    // Channel requests
    input  wire logic [2*DSP_DMA_CH_N-1:0] sel_in,      // Selects
    output logic      [DSP_IRQ_N-1:0]     irq_clr_out,  // Irq clears
    output logic      [DSP_DMA_REQ_N-1:0] dreq_clr_out  // Request clears
);
    logic [DSP_DMA_REQ_N-1:0] dclr_d;
    // A serviced channel clears the input its select names
    always_comb begin
        dclr_d = '0;
        for (int c = 0; c < DSP_DMA_CH_N; c++) begin
            if (ch_req_in[c] && sel_in[2*c+:2] != 2'h3) begin
                dclr_d[3*c+sel_in[2*c+:2]] = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        irq_clr_out  <= ack_en_in ? irq_in : '0;
        dreq_clr_out <= ack_en_in ? dclr_d : '0;
    end
endmodule
`default_nettype wire

// ===== tb/irr_tb_top.sv
// Self-checking bench for the request routing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
bind irr_top irr_chk #(.CPU_IRQS(CPU_IRQS), .DSP_IRQS(DSP_IRQS), .CPU_REQS(CPU_REQS)) chk_u (.clk_in, .rst_b_in,
    .dsp_mst_err_in, .dsp_mst_tgt_cpu_in, .cpu_mst_dsp_err_in, .berr_clr_in, .cpu_irq_src_in, .cpu_irq_out,
    .cpu_sw_nmi_in, .dsp_nmi_out, .dma_brk_in, .bus_snoop_in, .dsp_irq_pol_in, .dsp_irq_edge_in, .dsp_irq_out,
    .card1_dreq_in, .disp4_dreq_in, .shared_sel_disp_in, .cpu_dma_req_out);
module irr_tb_top;
    import irr_pkg::*;
    typedef struct packed {logic [15:0] dreq; logic c1, d4, sel; logic [15:0] exp;} irr_row_t;
    irr_row_t rows [6] = '{'{16'h0000, 1'b0, 1'b0, 1'b0, 16'hf0c0}, '{16'hf0c0, 1'b0, 1'b0, 1'b0, 16'h0000},
        '{16'h0001, 1'b1, 1'b0, 1'b0, 16'hf0e1}, '{16'h0020, 1'b0, 1'b1, 1'b0, 16'hf0c0},
        '{16'h0000, 1'b0, 1'b1, 1'b1, 16'hf0e0}, '{16'h1234, 1'b1, 1'b0, 1'b1, 16'he2d4}};
    logic        clk_in, rst_b_in, dsp_mst_err_in, dsp_mst_tgt_cpu_in, cpu_mst_dsp_err_in, cpu_sw_nmi_in;
    logic        dma_brk_in, dma_err_in, bus_snoop_in, dsp_nmi_out, card1_dreq_in, disp4_dreq_in;
    logic        shared_sel_disp_in, ack_en;
    logic [2:0]  berr_clr_in;
    logic [39:0] cpu_irq_src_in, cpu_irq_out;
    logic [47:0] dsp_irq_src_in, dsp_irq_pol_in, dsp_irq_edge_in, dsp_irq_clr_in, dsp_irq_out;
    logic [47:0] dsp_dreq_in, dsp_dreq_edge_in, dsp_dreq_clr_in;
    logic [31:0] dsp_ch_sel_in;
    logic [15:0] dsp_ch_req_out, cpu_dreq_in, cpu_dma_req_out;
    int          miscompares, checked;
    irr_top dut_u (.clk_in, .rst_b_in, .dsp_mst_err_in, .dsp_mst_tgt_cpu_in, .cpu_mst_dsp_err_in, .berr_clr_in,
        .cpu_irq_src_in, .cpu_irq_out, .cpu_sw_nmi_in, .dma_brk_in, .dma_err_in, .bus_snoop_in, .dsp_irq_src_in,
        .dsp_irq_pol_in, .dsp_irq_edge_in, .dsp_irq_clr_in, .dsp_irq_out, .dsp_nmi_out, .dsp_dreq_in,
        .dsp_dreq_edge_in, .dsp_dreq_clr_in, .dsp_ch_sel_in, .dsp_ch_req_out, .cpu_dreq_in, .card1_dreq_in,
        .disp4_dreq_in, .shared_sel_disp_in, .cpu_dma_req_out);
    irr_far far_u (.clk_in, .ack_en_in(ack_en), .irq_in(dsp_irq_out), .ch_req_in(dsp_ch_req_out),
        .sel_in(dsp_ch_sel_in), .irq_clr_out(dsp_irq_clr_in), .dreq_clr_out(dsp_dreq_clr_in));
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        repeat (2000) @(posedge clk_in);
        miscompares++;
        give_verdict();
    end
    initial begin
        {rst_b_in, dsp_mst_err_in, dsp_mst_tgt_cpu_in, cpu_mst_dsp_err_in, berr_clr_in, dma_brk_in, dma_err_in,
            bus_snoop_in, dsp_irq_src_in, dsp_irq_edge_in, dsp_dreq_in, dsp_dreq_edge_in, cpu_dreq_in,
            card1_dreq_in, disp4_dreq_in, shared_sel_disp_in, ack_en} = '0;
        {cpu_irq_src_in, cpu_sw_nmi_in, dsp_irq_pol_in, dsp_ch_sel_in} = '1;
        miscompares = 0;
        checked = 0;
        wt(3);
        `CHK({cpu_irq_out, dsp_nmi_out, cpu_dma_req_out, dsp_ch_req_out}, 73'h0)
        @(posedge clk_in) rst_b_in <= 1'b1;
        wt(1);
        `CHK({cpu_irq_out, dsp_nmi_out}, {40'h3b_ffff_ffff, 1'b1})
        @(posedge clk_in) {cpu_irq_src_in, cpu_sw_nmi_in} <= '0;
        wt(1);
        `CHK({cpu_irq_out, dsp_nmi_out}, 41'h0)
        $display("end of test: reset and core sources");
        foreach (rows[i]) begin
            @(posedge clk_in);
            {cpu_dreq_in, card1_dreq_in, disp4_dreq_in, shared_sel_disp_in} <= rows[i][34:16];
            wt(1);
            `CHK(cpu_dma_req_out, rows[i].exp)
        end
        $display("end of test: core dma table");
        @(posedge clk_in) {dsp_mst_err_in, dsp_mst_tgt_cpu_in} <= 2'h3;
        @(posedge clk_in) {dsp_mst_err_in, dsp_mst_tgt_cpu_in, cpu_mst_dsp_err_in} <= 3'h1;
        @(posedge clk_in) cpu_mst_dsp_err_in <= 1'b0;
        wt(6);
        `CHK(cpu_irq_out, 40'hc4_0000_0000)
        // Bus error lines are cleared only by an explicit request
        @(posedge clk_in) {berr_clr_in, dsp_mst_err_in} <= 4'hf;
        @(posedge clk_in) {berr_clr_in, dsp_mst_err_in} <= 4'h0;
        wt(1);
        `CHK(cpu_irq_out, 40'h80_0000_0000)
        @(posedge clk_in) berr_clr_in <= 3'h1;
        @(posedge clk_in) berr_clr_in <= 3'h0;
        wt(1);
        `CHK(cpu_irq_out, 40'h0)
        $display("end of test: bus errors");
        @(posedge clk_in) {bus_snoop_in, dma_brk_in, dma_err_in, dsp_irq_pol_in[0]} <= 4'he;
        wt(2);
        `CHK(dsp_irq_out, 48'h4d)
        @(posedge clk_in) {bus_snoop_in, dma_brk_in, dma_err_in, dsp_irq_pol_in[1:0]} <= 5'h1;
        dsp_irq_edge_in[1] <= 1'b1;
        dsp_irq_src_in[1] <= 1'b1;
        @(posedge clk_in) dsp_irq_src_in[1] <= 1'b0;
        @(posedge clk_in) dsp_irq_src_in[1] <= 1'b1;
        wt(5);
        `CHK(dsp_irq_out, 48'h2)
        @(posedge clk_in) ack_en <= 1'b1;
        wt(5);
        `CHK(dsp_irq_out, 48'h0)
        $display("end of test: dsp sources");
        @(posedge clk_in) ack_en <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge clk_in) dsp_ch_sel_in[3:2] <= s[1:0];
                dsp_dreq_in <= 48'h8 << k;
                wt(3);
                `CHK(dsp_ch_req_out, {14'h0, s == k, 1'b0})
            end
        end
        @(posedge clk_in) {dsp_ch_sel_in[31:30], dsp_dreq_edge_in[47], dsp_dreq_in} <= {3'h5, 48'h0};
        @(posedge clk_in) dsp_dreq_in[47] <= 1'b1;
        @(posedge clk_in) dsp_dreq_in[47] <= 1'b0;
        wt(5);
        `CHK(dsp_ch_req_out, 16'h8000)
        @(posedge clk_in) ack_en <= 1'b1;
        wt(6);
        `CHK(dsp_ch_req_out, 16'h0)
        $display("end of test: dsp dma");
        give_verdict();
    end
endmodule
`default_nettype wire
